// ===== hw/eeprom_target.sv
`include "eeprom_link_defines.svh"
// Link logic runs on the serial clock; start and stop are caught on data edges.
// The write timer runs on clk_sys_i, so a write cycle ends even with the bus idle.
module eeprom_target #(
   parameter eeprom_link_pkg::density_t DENSITY = eeprom_link_pkg::DENS_16K,
   parameter int ADDR_W = 11,
   parameter int WRITE_CYCLE_CLKS = `WRITE_CYCLE_CLKS
) (
   eeprom_link_if.target link,
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic select_pin_high_i,
   input wire logic select_pin_mid_i,
   input wire logic select_pin_low_i,
   output logic write_busy_o,
   output logic [ADDR_W-1:0] addr_ptr_o
);
   localparam int PAGE_LOW = (DENSITY == eeprom_link_pkg::DENS_1K2K) ? 3 : 4;
   localparam int CNT_W = $clog2(WRITE_CYCLE_CLKS + 1);
   localparam logic [CNT_W-1:0] CYCLE_LOAD = CNT_W'(WRITE_CYCLE_CLKS);

   // Erased array at power-up
   logic [7:0] mem [0:(1<<ADDR_W)-1] = '{default: 8'hff};

   // No reset pin on the link side: these flops take a power-up state, except sh_ff, out_ff and page_ff
   logic start_tg_ff = 1'b0;
   logic start_seen_ff = 1'b0;
   logic stop_tg_ff = 1'b0;
   logic stop_seen_ff = 1'b0;
   logic wr_tg_ff = 1'b0;
   eeprom_link_pkg::target_state_t st_ff = eeprom_link_pkg::T_IDLE;
   logic [3:0] bit_ff = 4'h0;
   logic ack_pend_ff = 1'b0;
   logic data_seen_ff = 1'b0;
   logic drive_low_ff = 1'b0;
   logic [ADDR_W-1:0] ptr_ff = {ADDR_W{1'b0}};
   logic [7:0] sh_ff;
   logic [7:0] out_ff;
   logic [2:0] page_ff;

   logic [2:0] sel_sync;
   logic busy_link;
   logic wr_tg_sync;
   logic wr_tg_q_ff;
   logic [CNT_W-1:0] wcnt_ff;
   logic [CNT_W-1:0] nxt_wcnt;
   logic busy_ff;
   logic [7:0] rx_byte;
   logic sel_match;
   logic dev_hit;
   logic start_ev;
   logic stop_ev;
   logic byte_end;

   bit_sync #(.WIDTH(3)) u_sel_sync (
      .clk_i(link.scl),
      .d_i({select_pin_high_i, select_pin_mid_i, select_pin_low_i}),
      .q_o(sel_sync)
   );

   // Busy level from the timer into the link domain
   bit_sync #(.WIDTH(1)) u_busy_sync (
      .clk_i(link.scl),
      .d_i(busy_ff),
      .q_o(busy_link)
   );

   // Write request toggle from the link into the timer domain
   bit_sync #(.WIDTH(1)) u_wr_sync (
      .clk_i(clk_sys_i),
      .d_i(wr_tg_ff),
      .q_o(wr_tg_sync)
   );

   always_ff @(negedge link.sda) begin
      if (link.scl) begin
         start_tg_ff <= ~start_tg_ff;
      end
   end

   // Stop acts at once, since the clock may stay high for good after it.
   // data_seen_ff is steady here: it last moved at a clock rise long before.
   always_ff @(posedge link.sda) begin
      if (link.scl) begin
         stop_tg_ff <= ~stop_tg_ff;
      end
   end

   always_ff @(posedge link.sda) begin
      if (link.scl && data_seen_ff) begin
         wr_tg_ff <= ~wr_tg_ff;
      end
   end

   always_ff @(posedge link.scl) begin
      start_seen_ff <= start_tg_ff;
      stop_seen_ff <= stop_tg_ff;
   end

   assign start_ev = start_tg_ff != start_seen_ff;
   assign stop_ev = stop_tg_ff != stop_seen_ff;
   assign rx_byte = {sh_ff[6:0], link.sda};
   assign byte_end = bit_ff == 4'h7 && !start_ev && !stop_ev;

   always_comb begin
      unique case (DENSITY)
         eeprom_link_pkg::DENS_1K2K: sel_match = rx_byte[3:1] == sel_sync;
         eeprom_link_pkg::DENS_4K: sel_match = rx_byte[3:2] == sel_sync[2:1];
         eeprom_link_pkg::DENS_8K: sel_match = rx_byte[3] == sel_sync[2];
         eeprom_link_pkg::DENS_16K: sel_match = 1'b1;
      endcase
   end

   // Refused while the write cycle runs, so a poll gets no acknowledge
   assign dev_hit = rx_byte[7:4] == `DEV_TYPE_CODE && sel_match && !busy_link;

   // Bit position: 0 to 7 are data bits, 8 is the acknowledge slot
   always_ff @(posedge link.scl) begin
      if (start_ev) begin
         bit_ff <= 4'h1;
      end else if (bit_ff == 4'h8) begin
         bit_ff <= 4'h0;
      end else begin
         bit_ff <= bit_ff + 4'h1;
      end
   end

   always_ff @(posedge link.scl) begin
      if (start_ev) begin
         sh_ff <= {7'h00, link.sda};
      end else begin
         sh_ff <= rx_byte;
      end
   end

   always_ff @(posedge link.scl) begin
      if (start_ev) begin
         st_ff <= eeprom_link_pkg::T_DEVADDR;
      end else if (stop_ev) begin
         st_ff <= eeprom_link_pkg::T_IDLE;
      end else if (byte_end) begin
         unique case (st_ff)
            eeprom_link_pkg::T_DEVADDR: begin
               if (!dev_hit) begin
                  st_ff <= eeprom_link_pkg::T_IGNORE;
               end else if (rx_byte[0]) begin
                  st_ff <= eeprom_link_pkg::T_RDATA;
               end else begin
                  st_ff <= eeprom_link_pkg::T_WORDADDR;
               end
            end
            eeprom_link_pkg::T_WORDADDR: st_ff <= eeprom_link_pkg::T_WDATA;
            eeprom_link_pkg::T_WDATA: st_ff <= eeprom_link_pkg::T_WDATA;
            eeprom_link_pkg::T_RDATA: st_ff <= eeprom_link_pkg::T_RDATA;
            eeprom_link_pkg::T_IDLE: st_ff <= eeprom_link_pkg::T_IDLE;
            eeprom_link_pkg::T_IGNORE: st_ff <= eeprom_link_pkg::T_IGNORE;
         endcase
      end else if (bit_ff == 4'h8 && st_ff == eeprom_link_pkg::T_RDATA && link.sda) begin
         // Missing controller acknowledge: stay off the bus until the next start
         st_ff <= eeprom_link_pkg::T_IGNORE;
      end
   end

   // Set at the eighth rise of a byte we take, cleared at the slot rise
   always_ff @(posedge link.scl) begin
      if (byte_end && st_ff == eeprom_link_pkg::T_DEVADDR) begin
         ack_pend_ff <= dev_hit;
      end else if (byte_end && (st_ff == eeprom_link_pkg::T_WORDADDR || st_ff == eeprom_link_pkg::T_WDATA)) begin
         ack_pend_ff <= 1'b1;
      end else begin
         ack_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge link.scl) begin
      if (byte_end && st_ff == eeprom_link_pkg::T_DEVADDR && dev_hit) begin
         page_ff <= rx_byte[3:1];
      end
   end

   always_ff @(posedge link.scl) begin
      if (byte_end && st_ff == eeprom_link_pkg::T_WORDADDR) begin
         unique case (DENSITY)
            eeprom_link_pkg::DENS_1K2K: ptr_ff <= ADDR_W'(rx_byte);
            eeprom_link_pkg::DENS_4K: ptr_ff <= ADDR_W'({page_ff[0], rx_byte});
            eeprom_link_pkg::DENS_8K: ptr_ff <= ADDR_W'({page_ff[1:0], rx_byte});
            eeprom_link_pkg::DENS_16K: ptr_ff <= ADDR_W'({page_ff, rx_byte});
         endcase
      end else if (byte_end && st_ff == eeprom_link_pkg::T_WDATA) begin
         ptr_ff[PAGE_LOW-1:0] <= ptr_ff[PAGE_LOW-1:0] + PAGE_LOW'(1);
      end else if (byte_end && st_ff == eeprom_link_pkg::T_RDATA) begin
         ptr_ff <= ptr_ff + ADDR_W'(1);
      end
   end

   always_ff @(posedge link.scl) begin
      if (byte_end && st_ff == eeprom_link_pkg::T_WDATA) begin
         mem[ptr_ff] <= rx_byte;
      end
   end

   always_ff @(posedge link.scl) begin
      if (start_ev) begin
         data_seen_ff <= 1'b0;
      end else if (byte_end && st_ff == eeprom_link_pkg::T_WDATA) begin
         data_seen_ff <= 1'b1;
      end
   end

   // Device ack and controller ack both leave data low in the slot
   always_ff @(posedge link.scl) begin
      if (bit_ff == 4'h8 && st_ff == eeprom_link_pkg::T_RDATA && !link.sda && !start_ev && !stop_ev) begin
         out_ff <= mem[ptr_ff];
      end
   end

   // Data moves only while the clock is low
   always_ff @(negedge link.scl) begin
      if (start_ev) begin
         drive_low_ff <= 1'b0;
      end else if (bit_ff == 4'h8) begin
         drive_low_ff <= ack_pend_ff;
      end else if (st_ff == eeprom_link_pkg::T_RDATA) begin
         drive_low_ff <= !out_ff[3'(4'h7 - bit_ff)];
      end else begin
         drive_low_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      wr_tg_q_ff <= wr_tg_sync;
   end

   always_comb begin
      nxt_wcnt = wcnt_ff;
      if (wr_tg_sync != wr_tg_q_ff) begin
         nxt_wcnt = CYCLE_LOAD;
      end else if (wcnt_ff != {CNT_W{1'b0}}) begin
         nxt_wcnt = wcnt_ff - CNT_W'(1);
      end
   end

   // A system reset also ends a write cycle in progress
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wcnt_ff <= {CNT_W{1'b0}};
         busy_ff <= 1'b0;
      end else begin
         wcnt_ff <= nxt_wcnt;
         busy_ff <= nxt_wcnt != {CNT_W{1'b0}};
      end
   end

   // Open drain: only ever pulls low
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = drive_low_ff;
   assign addr_ptr_o = ptr_ff;
   assign write_busy_o = busy_ff;
endmodule

// ===== hw/eeprom_link_defines.svh
`ifndef EEPROM_LINK_DEFINES_SVH
`define EEPROM_LINK_DEFINES_SVH
`define DEV_TYPE_CODE 4'ha
`define WRITE_CYCLE_TIME_MS 32'h0000000a
`define SYS_CLK_HZ 32'h017d7840
// System clocks in one internal write cycle
`define WRITE_CYCLE_CLKS (`SYS_CLK_HZ / 32'h000003e8 * `WRITE_CYCLE_TIME_MS)
`endif

// ===== hw/eeprom_link_pkg.sv
package eeprom_link_pkg;
   typedef enum logic [1:0] {DENS_1K2K, DENS_4K, DENS_8K, DENS_16K} density_t;
   typedef enum logic [2:0] {T_IDLE, T_DEVADDR, T_WORDADDR, T_WDATA, T_RDATA, T_IGNORE} target_state_t;
endpackage

// ===== hw/eeprom_link_if.sv
interface eeprom_link_if;
   logic scl;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda_ctl_o;
   logic sda_ctl_oe;
   wire sda = !((sda_dev_oe && !sda_dev_o) || (sda_ctl_oe && !sda_ctl_o));
   modport target (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport controller (output scl, input sda, output sda_ctl_o, output sda_ctl_oe);
endinterface

// ===== hw/bit_sync.sv
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_ff;
   always_ff @(posedge clk_i) begin
      meta_ff <= d_i;
      q_o <= meta_ff;
   end
endmodule

// ===== tb/eeprom_link_props.sv
module eeprom_link_props (
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic sda_ctl_oe
);
   logic st_ff = 1'b0;
   logic sn_ff = 1'b0;
   wire nf = st_ff != sn_ff;
   // Start seen on sda, handed to scl by toggle
   always_ff @(negedge sda) if (scl) st_ff <= !st_ff;
   always_ff @(posedge scl) sn_ff <= st_ff;
   default clocking @(posedge scl); endclocking
   sequence wr_ack; nf ##7 !sda ##1 sda_dev_oe; endsequence
   sequence rd_ack; nf ##7 sda ##1 sda_dev_oe; endsequence
   low_only_a: assert property (sda_dev_oe |-> !sda_dev_o) else $error("high");
   no_clash_a: assert property (sda_dev_oe |-> !sda_ctl_oe) else $error("clash");
   addr_quiet_a: assert property (nf |-> !sda_dev_oe [*8]) else $error("addr");
   bad_msb_a: assert property (nf && !sda |-> ##8 !sda_dev_oe) else $error("msb");
   bad_bit2_a: assert property (nf ##1 sda |-> ##7 !sda_dev_oe) else $error("bit2");
   word_quiet_a: assert property (wr_ack |=> !sda_dev_oe [*8]) else $error("word");
   word_ack_a: assert property (wr_ack |-> ##9 sda_dev_oe) else $error("no ack");
   ack_slot_a: assert property (rd_ack |-> ##9 !sda_dev_oe) else $error("slot");
endmodule

// ===== tb/serial_eeprom_bus_target_tb.sv
module serial_eeprom_bus_target_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic write_busy_o;
   logic [10:0] addr_ptr_o;
   logic [8:0] r;
   int n;
   int num_errors = 0;
   int checks = 0;
   eeprom_link_if lnk ();
   eeprom_target #(.WRITE_CYCLE_CLKS(200)) u_eeprom_target (.link(lnk), .clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .select_pin_high_i(1'b0), .select_pin_mid_i(1'b0), .select_pin_low_i(1'b0),
      .write_busy_o(write_busy_o), .addr_ptr_o(addr_ptr_o));
   eeprom_link_props u_eeprom_link_props (.scl(lnk.scl), .sda(lnk.sda), .sda_dev_o(lnk.sda_dev_o),
      .sda_dev_oe(lnk.sda_dev_oe), .sda_ctl_oe(lnk.sda_ctl_oe));
   initial forever #20 clk_sys_i = !clk_sys_i;
   task automatic chk(input string s, input logic [10:0] e, input logic [10:0] v);
      checks++;
      if (v !== e) begin
         num_errors++;
         $display("BAD %s exp %h seen %h", s, e, v);
      end
   endtask
   task automatic wrap_up();
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One change per step so sda never moves on an scl edge
   task automatic set(input logic c, input logic d);
      @(posedge clk_sys_i);
      #1;
      lnk.scl = c;
      lnk.sda_ctl_oe = !d;
   endtask
   // cond(1,0) is a start, cond(0,1) a stop
   task automatic cond(input logic a, input logic b);
      set(0, !lnk.sda_ctl_oe);
      set(0, a);
      set(1, a);
      set(1, b);
   endtask
   task automatic xfer(input logic [8:0] w);
      for (int i = 8; i >= 0; i--) begin
         set(0, !lnk.sda_ctl_oe);
         set(0, w[i]);
         set(1, w[i]);
         set(1, w[i]);
         r[i] = lnk.sda;
      end
   endtask
   task automatic wb(input logic [7:0] b, input logic a);
      xfer({b, 1'b1});
      chk("ack", {10'h000, a}, {10'h000, r[0]});
   endtask
   initial begin
      lnk.scl = 1'b1;
      lnk.sda_ctl_o = 1'b0;
      lnk.sda_ctl_oe = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #1;
      reset_i = 1'b0;
      cond(1, 0);
      wb(8'h50, 1'b1);
      cond(0, 1);
      cond(1, 0);
      wb(8'haa, 1'b0);
      wb(8'h0e, 1'b0);
      for (int i = 0; i < 3; i++) wb(8'h3c + 8'(i), 1'b0);
      cond(0, 1);
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk("busy", 11'h001, {10'h000, write_busy_o});
      chk("ptr", 11'h501, addr_ptr_o);
      // Polls supply the scl edges that carry the busy level into the link domain
      for (n = 0; n < 12; n++) begin
         cond(1, 0);
         xfer({8'haa, 1'b1});
         if (r[0] === 1'b0) break;
         cond(0, 1);
      end
      chk("poll", 11'h001, {10'h000, n > 0 && n < 12});
      if (n == 12) wrap_up();
      wb(8'h00, 1'b0);
      cond(0, 1);
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk("busy", 11'h000, {10'h000, write_busy_o});
      chk("ptr", 11'h500, addr_ptr_o);
      cond(1, 0);
      wb(8'ha1, 1'b0);
      xfer({8'hff, 1'b0});
      chk("rd0", 11'h03e, {3'h0, r[8:1]});
      xfer({8'hff, 1'b1});
      chk("rd1", 11'h0ff, {3'h0, r[8:1]});
      cond(0, 1);
      chk("ptr", 11'h502, addr_ptr_o);
      cond(1, 0);
      wb(8'hae, 1'b0);
      wb(8'hff, 1'b0);
      cond(1, 0);
      wb(8'haf, 1'b0);
      xfer({8'hff, 1'b0});
      chk("rd2", 11'h0ff, {3'h0, r[8:1]});
      xfer({8'hff, 1'b1});
      cond(0, 1);
      chk("ptr", 11'h001, addr_ptr_o);
      wrap_up();
   end
endmodule
